// >>> core/irq_flags_defs.vh
// register map, field positions, encodings and reset values of the
// external request flag block; definitions only, included by bare name.
`ifndef IRQ_FLAGS_DEFS_VH
`define IRQ_FLAGS_DEFS_VH

// ============================================================
// register byte offsets
`define OFS_FLAGS 8'h00
`define OFS_REQ_SENSE 8'h04
`define OFS_PORT_SENSE 8'h08
`define OFS_PORT_EN 8'h0C
`define OFS_EVT_STATUS 8'h10
`define OFS_EVT_MASK 8'h14

// ============================================================
// field positions in the flag register
`define FLAG_GRP_LOW_BIT 7
`define FLAG_GRP_HIGH_BIT 6
`define FLAG_PIN_MSB 5

// ============================================================
// sense select codes of an external request pin
`define SENSE_FALL 2'b00
`define SENSE_RISE 2'b01
`define SENSE_LOW 2'b10
`define SENSE_HIGH 2'b11

// ============================================================
// reset values
`define RST_FLAGS 8'h00
`define RST_REQ_SENSE 12'h000
`define RST_PORT_SENSE 16'h0000
`define RST_PORT_EN 16'h0000
`define RST_EVT_STATUS 8'h00
`define RST_EVT_MASK 8'h00

// ============================================================
// bus responses
`define RESP_OKAY 2'b00
`define RESP_SLVERR 2'b10

`endif

// >>> core/external_irq_request_flags.v
// external request flag register with its sense and enable controls,
// an event status/mask pair and one level interrupt, behind AXI4-Lite.
// assumes all pins are asynchronous to ref_clk and the bus master is
// on ref_clk; one write and one read outstanding at most.
//
// Decided for this implementation: the AXI4-Lite interface to the registers and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
`include "irq_flags_defs.vh"

// Summary of operation
// - eight-bit flag register, all zero at reset
// - bit 7 set while pins 0-7 request
// - bit 6 set while pins 8-15 request
// - bits 7,6 read-only; bits 5-0 read/write
// - flag bit n follows request pin n
// - edge flag latches; cleared by 0 after read-1
// - level flag tracks pin, writes ignored
// - two-bit select: fall, rise, low, high
// - port select bit picks active-low or active-high
// - port pin requests need its enable set
module external_irq_request_flags #(
  parameter NUM_REQ = 6,
  parameter NUM_PORT = 16,
  parameter ADDR_W = 8
) (
  input wire ref_clk,
  input wire resetn,
  input wire [NUM_REQ-1:0] external_request_pin,
  input wire [NUM_PORT-1:0] port_interrupt_pin,
  input wire [ADDR_W-1:0] awaddr,
  input wire awvalid,
  output wire awready,
  input wire [31:0] wdata,
  input wire [3:0] wstrb,
  input wire wvalid,
  output wire wready,
  output reg [1:0] bresp,
  output reg bvalid,
  input wire bready,
  input wire [ADDR_W-1:0] araddr,
  input wire arvalid,
  output wire arready,
  output reg [31:0] rdata,
  output reg [1:0] rresp,
  output reg rvalid,
  input wire rready,
  output reg irq
);

  // ============================================================
  // pin synchronisers
  reg [NUM_REQ-1:0] req_meta_r;
  reg [NUM_REQ-1:0] req_sync_r;
  reg [NUM_REQ-1:0] req_prev_r;
  reg [NUM_PORT-1:0] port_meta_r;
  reg [NUM_PORT-1:0] port_sync_r;

  always @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      req_meta_r <= {NUM_REQ{1'b0}};
      req_sync_r <= {NUM_REQ{1'b0}};
      req_prev_r <= {NUM_REQ{1'b0}};
      port_meta_r <= {NUM_PORT{1'b0}};
      port_sync_r <= {NUM_PORT{1'b0}};
    end else begin
      req_meta_r <= external_request_pin;
      req_sync_r <= req_meta_r;
      req_prev_r <= req_sync_r;
      port_meta_r <= port_interrupt_pin;
      port_sync_r <= port_meta_r;
    end
  end

  // ============================================================
  // control registers
  reg [2*NUM_REQ-1:0] req_sense_r;
  reg [NUM_PORT-1:0] port_sense_r;
  reg [NUM_PORT-1:0] port_en_r;
  reg [7:0] evt_status_r;
  reg [7:0] evt_mask_r;
  reg [NUM_REQ-1:0] pin_flag_r;
  reg [NUM_REQ-1:0] armed_r;
  reg [7:0] flags_prev_r;

  // ============================================================
  // port groups
  wire [NUM_PORT-1:0] port_active;
  genvar p;
  generate
    for (p = 0; p < NUM_PORT; p = p + 1) begin : g_port
      // select bit 1 means active high, 0 active low
      assign port_active[p] = port_en_r[p] & (port_sync_r[p] == port_sense_r[p]);
    end
  endgenerate

  wire port_group_low_flag = |port_active[NUM_PORT/2-1:0];
  wire port_group_high_flag = |port_active[NUM_PORT-1:NUM_PORT/2];
  wire [7:0] external_request_flags;
  assign external_request_flags = {port_group_low_flag, port_group_high_flag, pin_flag_r};

  // ============================================================
  // write channel
  reg aw_held_r;
  reg w_held_r;
  reg [ADDR_W-1:0] aw_addr_r;
  reg [31:0] w_data_r;
  reg [3:0] w_strb_r;

  assign awready = !aw_held_r && !bvalid;
  assign wready = !w_held_r && !bvalid;
  wire wr_fire = aw_held_r && w_held_r && !bvalid;
  wire [7:0] wr_ofs = aw_addr_r[7:0];
  wire wr_lane0 = w_strb_r[0];
  wire wr_lane1 = w_strb_r[1];
  wire wr_flags = wr_fire && (wr_ofs == `OFS_FLAGS) && wr_lane0;
  wire wr_mapped = (wr_ofs == `OFS_FLAGS) || (wr_ofs == `OFS_REQ_SENSE) ||
    (wr_ofs == `OFS_PORT_SENSE) || (wr_ofs == `OFS_PORT_EN) ||
    (wr_ofs == `OFS_EVT_STATUS) || (wr_ofs == `OFS_EVT_MASK);

  always @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      aw_held_r <= 1'b0;
      w_held_r <= 1'b0;
      aw_addr_r <= {ADDR_W{1'b0}};
      w_data_r <= 32'h0000_0000;
      w_strb_r <= 4'h0;
      bvalid <= 1'b0;
      bresp <= `RESP_OKAY;
    end else begin
      if (awvalid && awready) begin
        aw_held_r <= 1'b1;
        aw_addr_r <= awaddr;
      end
      if (wvalid && wready) begin
        w_held_r <= 1'b1;
        w_data_r <= wdata;
        w_strb_r <= wstrb;
      end
      if (wr_fire) begin
        aw_held_r <= 1'b0;
        w_held_r <= 1'b0;
        bvalid <= 1'b1;
        bresp <= wr_mapped ? `RESP_OKAY : `RESP_SLVERR;
      end else if (bvalid && bready) begin
        bvalid <= 1'b0;
      end
    end
  end

  // ============================================================
  // read channel
  assign arready = !rvalid;
  wire rd_fire = arvalid && arready;
  wire rd_flags = rd_fire && (araddr[7:0] == `OFS_FLAGS);
  reg [31:0] rd_mux;
  reg rd_ok;

  always @* begin
    rd_mux = 32'h0000_0000;
    rd_ok = 1'b1;
    case (araddr[7:0])
      `OFS_FLAGS: rd_mux[7:0] = external_request_flags;
      `OFS_REQ_SENSE: rd_mux[2*NUM_REQ-1:0] = req_sense_r;
      `OFS_PORT_SENSE: rd_mux[NUM_PORT-1:0] = port_sense_r;
      `OFS_PORT_EN: rd_mux[NUM_PORT-1:0] = port_en_r;
      `OFS_EVT_STATUS: rd_mux[7:0] = evt_status_r;
      `OFS_EVT_MASK: rd_mux[7:0] = evt_mask_r;
      default: rd_ok = 1'b0;
    endcase
  end

  always @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      rvalid <= 1'b0;
      rdata <= 32'h0000_0000;
      rresp <= `RESP_OKAY;
    end else begin
      if (rd_fire) begin
        rvalid <= 1'b1;
        rdata <= rd_mux;
        rresp <= rd_ok ? `RESP_OKAY : `RESP_SLVERR;
      end else if (rvalid && rready) begin
        rvalid <= 1'b0;
      end
    end
  end

  // ============================================================
  // sense and enable registers, byte lanes honoured
  always @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      req_sense_r <= `RST_REQ_SENSE;
      port_sense_r <= `RST_PORT_SENSE;
      port_en_r <= `RST_PORT_EN;
      evt_mask_r <= `RST_EVT_MASK;
    end else if (wr_fire) begin
      if (wr_ofs == `OFS_REQ_SENSE) begin
        if (wr_lane0) req_sense_r[7:0] <= w_data_r[7:0];
        if (wr_lane1) req_sense_r[11:8] <= w_data_r[11:8];
      end
      if (wr_ofs == `OFS_PORT_SENSE) begin
        if (wr_lane0) port_sense_r[7:0] <= w_data_r[7:0];
        if (wr_lane1) port_sense_r[15:8] <= w_data_r[15:8];
      end
      if (wr_ofs == `OFS_PORT_EN) begin
        if (wr_lane0) port_en_r[7:0] <= w_data_r[7:0];
        if (wr_lane1) port_en_r[15:8] <= w_data_r[15:8];
      end
      if (wr_ofs == `OFS_EVT_MASK && wr_lane0) evt_mask_r <= w_data_r[7:0];
    end
  end

  // ============================================================
  // external request pin flags
  genvar n;
  generate
    for (n = 0; n < NUM_REQ; n = n + 1) begin : g_req
      wire [1:0] sel = req_sense_r[2*n+1:2*n];
      wire level_mode = sel[1];
      // edge from the second sync stage against its delayed copy
      wire edge_hit = (sel == `SENSE_FALL) ? (req_prev_r[n] & ~req_sync_r[n]) :
        (~req_prev_r[n] & req_sync_r[n]);
      wire level_on = sel[0] ? req_sync_r[n] : ~req_sync_r[n];
      // a clear needs a prior read that returned 1 for this bit
      wire clr_ok = wr_flags && !w_data_r[n] && armed_r[n];

      always @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
          pin_flag_r[n] <= 1'b0;
          armed_r[n] <= 1'b0;
        end else if (level_mode) begin
          pin_flag_r[n] <= level_on;
          armed_r[n] <= 1'b0;
        end else begin
          // a new edge wins over a clear in the same cycle
          if (edge_hit) begin
            pin_flag_r[n] <= 1'b1;
            armed_r[n] <= armed_r[n] & ~clr_ok;
          end else if (clr_ok) begin
            pin_flag_r[n] <= 1'b0;
            armed_r[n] <= 1'b0;
          end else if (rd_flags && pin_flag_r[n]) begin
            armed_r[n] <= 1'b1;
          end
        end
      end
    end
  endgenerate

  // ============================================================
  // event status, mask and interrupt
  // an event is any flag bit rising, including the read-only group bits
  wire [7:0] evt_rise = external_request_flags & ~flags_prev_r;
  wire [7:0] evt_clr = (wr_fire && wr_ofs == `OFS_EVT_STATUS && wr_lane0) ?
    w_data_r[7:0] : 8'h00;

  always @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      flags_prev_r <= `RST_FLAGS;
      evt_status_r <= `RST_EVT_STATUS;
      irq <= 1'b0;
    end else begin
      flags_prev_r <= external_request_flags;
      evt_status_r <= (evt_status_r & ~evt_clr) | evt_rise;
      irq <= |(((evt_status_r & ~evt_clr) | evt_rise) & evt_mask_r);
    end
  end

endmodule
`default_nettype wire

// >>> tb/irq_pins_model.sv
// model of the external request and port interrupt pins
// assumes the bench sets the wanted pin levels on the command inputs
`timescale 1ns/1ps
`default_nettype none
module irq_pins_model (
  input wire logic [5:0] req_cmd,
  input wire logic [15:0] port_cmd,
  output logic [5:0] external_request_pin,
  output logic [15:0] port_interrupt_pin
);
  // pins move off the clock grid, as real asynchronous inputs do
  assign #7 external_request_pin = req_cmd;
  assign #7 port_interrupt_pin = port_cmd;
endmodule
`default_nettype wire

// >>> tb/external_irq_request_flags_checker.sv
// bus timing checks of the request flag block
// assumes it is bound to the top module and sees its ports only
`timescale 1ns/1ps
`default_nettype none
module external_irq_request_flags_checker #(
  parameter ADDR_W = 8
) (
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic awready,
  input wire logic wready,
  input wire logic bvalid,
  input wire logic bready,
  input wire logic [1:0] bresp,
  input wire logic [ADDR_W-1:0] araddr,
  input wire logic arvalid,
  input wire logic arready,
  input wire logic [31:0] rdata,
  input wire logic [1:0] rresp,
  input wire logic rvalid,
  input wire logic rready
);
  reg [ADDR_W-1:0] ra_r;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!resetn);
  always @(posedge ref_clk or negedge resetn) begin
    if (!resetn) ra_r <= 0;
    else if (arvalid && arready) ra_r <= araddr;
  end
  // ============================================================
  // read side
  property p_upper_zero; rvalid && ra_r == 0 |-> rdata[31:8] == 0; endproperty
  a_upper_zero: assert property (p_upper_zero) else $error("flag read upper bits");
  property p_unmapped; rvalid && ra_r > 8'h14 |-> rresp == 2'b10 && rdata == 0; endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read answer");
  property p_okay; rvalid && ra_r <= 8'h14 |-> rresp == 2'b00; endproperty
  a_okay: assert property (p_okay) else $error("mapped read not okay");
  property p_rhold; rvalid && !rready |=> rvalid && $stable(rdata); endproperty
  a_rhold: assert property (p_rhold) else $error("read answer dropped");
  property p_ranswer; arvalid && arready |=> rvalid; endproperty
  a_ranswer: assert property (p_ranswer) else $error("read answer late");
  property p_arblock; rvalid |-> !arready; endproperty
  a_arblock: assert property (p_arblock) else $error("read taken while busy");
  // ============================================================
  // write side
  property p_bhold; bvalid && !bready |=> bvalid && $stable(bresp); endproperty
  a_bhold: assert property (p_bhold) else $error("write answer dropped");
  property p_wblock; bvalid |-> !awready && !wready; endproperty
  a_wblock: assert property (p_wblock) else $error("write taken while busy");
endmodule
bind external_irq_request_flags external_irq_request_flags_checker #(.ADDR_W(ADDR_W))
  external_irq_request_flags_checker_inst (.ref_clk(ref_clk), .resetn(resetn),
  .awready(awready), .wready(wready), .bvalid(bvalid), .bready(bready), .bresp(bresp),
  .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
  .rvalid(rvalid), .rready(rready));
`default_nettype wire

// >>> tb/test_external_irq_request_flags.sv
// self-checking bench of the request flag block
// assumes the pin model and the bound checker are compiled alongside
`timescale 1ns/1ps
`default_nettype none
module test_external_irq_request_flags;
  logic ref_clk, resetn, awvalid, wvalid, bready, arvalid, rready;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata;
  logic [3:0] wstrb;
  logic [5:0] req_cmd, r, q;
  logic [15:0] port_cmd, pe, ps;
  wire awready, wready, bvalid, arready, rvalid, irq;
  wire [1:0] bresp, rresp;
  wire [31:0] rdata;
  wire [5:0] ext_pins;
  wire [15:0] port_pins;
  logic [33:0] exp_q[$];
  int miscompares, total_checks, cycles;
  irq_pins_model irq_pins_model_inst (.req_cmd(req_cmd), .port_cmd(port_cmd),
    .external_request_pin(ext_pins), .port_interrupt_pin(port_pins));
  external_irq_request_flags external_irq_request_flags_inst (.ref_clk(ref_clk),
    .resetn(resetn), .external_request_pin(ext_pins), .port_interrupt_pin(port_pins),
    .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
    .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
    .rvalid(rvalid), .rready(rready), .irq(irq));
  // ============================================================
  // checking and closing
  task check(input [33:0] seen, input [33:0] expd);
    total_checks++;
    if (seen !== expd) begin
      miscompares++;
      $display("mismatch t=%0t seen=%h exp=%h", $time, seen, expd);
    end
  endtask
  task results;
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  function logic grp(input [7:0] e, input [7:0] p, input [7:0] s);
    grp = |(e & ~(p ^ s));
  endfunction
  // ============================================================
  // bus master
  task wr(input [7:0] a, input [31:0] d);
    @(posedge ref_clk);
    awaddr <= a; wdata <= d; awvalid <= 1; wvalid <= 1; bready <= 1;
    while (awvalid || wvalid) begin
      @(posedge ref_clk);
      if (awready) awvalid <= 0;
      if (wready) wvalid <= 0;
    end
    do @(posedge ref_clk); while (bvalid !== 1'b1);
    check({32'h0, bresp}, {32'h0, (a > 8'h14) ? 2'b10 : 2'b00});
    bready <= 0;
  endtask
  task rd(input [7:0] a, input [33:0] e);
    @(posedge ref_clk);
    araddr <= a; arvalid <= 1; rready <= 1;
    exp_q.push_back(e);
    do @(posedge ref_clk); while (arready !== 1'b1);
    arvalid <= 0;
    do @(posedge ref_clk); while (rvalid !== 1'b1);
    rready <= 0;
  endtask
  always @(posedge ref_clk) if (rvalid === 1'b1 && rready === 1'b1)
    check({rresp, rdata}, exp_q.pop_front());
  // a hang ends the run well after the few hundred cycles the tests need
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 20000) begin
      miscompares++;
      results;
    end
  end
  initial begin
    ref_clk = 0;
    forever #20 ref_clk = ~ref_clk;
  end
  // ============================================================
  // scenarios
  initial begin
    {resetn, awvalid, wvalid, bready, arvalid, rready, awaddr, araddr, wdata} = 0;
    wstrb = 4'hf; req_cmd = 0; port_cmd = 0;
    void'($urandom(32'h9903_de10));
    r = 6'($urandom) | 6'h21;
    q = 6'($urandom) | 6'h12;
    repeat (20) @(posedge ref_clk);
    resetn <= 1;
    rd(8'h00, 34'h0);
    rd(8'h20, {2'b10, 32'h0});
    wr(8'h20, 32'hffff_ffff);
    wr(8'h04, 32'h555);
    req_cmd <= r;
    repeat (6) @(posedge ref_clk);
    wr(8'h00, 32'h0);
    rd(8'h00, {28'h0, r});
    wr(8'h00, 32'h0);
    rd(8'h00, 34'h0);
    wr(8'h04, 32'h0);
    req_cmd <= 0;
    repeat (6) @(posedge ref_clk);
    rd(8'h00, {28'h0, r});
    wr(8'h04, 32'hfff);
    req_cmd <= q;
    repeat (6) @(posedge ref_clk);
    wr(8'h00, 32'h0);
    rd(8'h00, {28'h0, q});
    wr(8'h04, 32'haaa);
    repeat (4) @(posedge ref_clk);
    rd(8'h00, {28'h0, ~q});
    wr(8'h04, 32'hfff);
    for (int i = 0; i < 8; i++) begin
      pe = 16'($urandom); ps = 16'($urandom);
      wr(8'h08, {16'h0, ps});
      wr(8'h0c, {16'h0, pe});
      port_cmd <= 16'($urandom);
      repeat (6) @(posedge ref_clk);
      rd(8'h00, {26'h0, grp(pe[7:0], port_cmd[7:0], ps[7:0]),
        grp(pe[15:8], port_cmd[15:8], ps[15:8]), q});
    end
    wr(8'h0c, 32'h0);
    wr(8'h00, 32'hc0);
    rd(8'h00, {28'h0, q});
    req_cmd <= 0;
    repeat (6) @(posedge ref_clk);
    wr(8'h10, 32'hff);
    wr(8'h14, 32'h1);
    req_cmd <= 1;
    repeat (6) @(posedge ref_clk);
    check({33'h0, irq}, 34'h1);
    wr(8'h14, 32'h0);
    repeat (3) @(posedge ref_clk);
    check({33'h0, irq}, 34'h0);
    wr(8'h14, 32'h1);
    repeat (3) @(posedge ref_clk);
    check({33'h0, irq}, 34'h1);
    wr(8'h10, 32'h1);
    repeat (3) @(posedge ref_clk);
    check({33'h0, irq}, 34'h0);
    rd(8'h10, 34'h0);
    results;
  end
endmodule
`default_nettype wire
